// ### core/lpm_pkg.sv
package lpm_pkg;

  // Operating modes of the controller
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,   // Core and peripherals running
    MODE_IDLE   = 2'b01,   // Core halted, selected peripherals run
    MODE_STOP   = 2'b10,   // Everything stopped but port, clock unit, RAM
    MODE_WARMUP = 2'b11    // Oscillator settling after full stop
  } mode_t;

  // Standby select field
  localparam int          STBY_W          = 3;
  localparam logic [2:0]  STBY_FULL_STOP  = 3'h1;  // Full stop encoding
  localparam logic [2:0]  STBY_HALT       = 3'h3;  // Halt encoding
  localparam logic [2:0]  STBY_RESET      = 3'h0;  // Field value after reset

  // Module clock enable vector layout
  localparam int MOD_W      = 15;
  localparam int MOD_CORE   = 0;   // Processor core
  localparam int MOD_DMA    = 1;   // Dma controller
  localparam int MOD_IO     = 2;   // IO port
  localparam int MOD_SERIAL = 3;   // Serial channels
  localparam int MOD_I2C    = 4;   // I2C
  localparam int MOD_TMREV  = 5;   // Timer event counter
  localparam int MOD_TMR16  = 6;   // Sixteen bit timer
  localparam int MOD_WDT    = 7;   // Watchdog timer
  localparam int MOD_ADC    = 8;   // Converter
  localparam int MOD_CLKGEN = 9;   // Clock generator
  localparam int MOD_PLL    = 10;  // Multiplier
  localparam int MOD_EXTOSC = 11;  // External fast oscillator
  localparam int MOD_LVD    = 12;  // Low voltage detector
  localparam int MOD_INTOSC = 13;  // Internal fast oscillator
  localparam int MOD_RAM    = 14;  // Main RAM

  localparam logic [14:0] RUN_ALL        = 15'h7FFF;  // Every module clocked
  localparam logic [14:0] HALT_FIXED_RUN = 15'h7216;  // Always on in halt
  localparam logic [14:0] HALT_SELECT    = 15'h0DE8;  // Software selectable in halt
  localparam logic [14:0] STOP_RUN       = 15'h4204;  // IO, clock unit, RAM
  localparam logic [14:0] RUN_NONE       = 15'h0000;  // Nothing clocked

  // Clock configuration bits
  localparam int         CFG_W         = 6;
  localparam int         CFG_PLL_SEL   = 0;  // Multiplier output select
  localparam int         CFG_PLL_ON    = 1;  // Multiplier enable
  localparam int         CFG_INT_EN    = 2;  // Internal oscillator enable
  localparam int         CFG_EXT_EN    = 3;  // External oscillator enable
  localparam int         CFG_OSC_SEL   = 4;  // Oscillator source select
  localparam int         CFG_WUP_SEL   = 5;  // Warm-up source select
  localparam logic [5:0] CFG_RESET     = 6'h04;  // Internal oscillator only

  // Warm-up counter and pins
  localparam int          WU_W       = 12;
  localparam logic [11:0] WU_ZERO    = 12'h000;
  localparam logic [11:0] WU_ONE     = 12'h001;
  localparam int          EXT_INT_N  = 6;
  localparam int          PORT_W     = 8;

endpackage : lpm_pkg

// ### core/warmup_if.sv
`timescale 1ns/10ps
interface warmup_if;
  logic                        start;  // One cycle pulse to launch count
  logic [lpm_pkg::WU_W-1:0]    count;  // Warm-up length in cycles
  logic                        busy;   // Counting in progress
  logic                        done;   // One cycle pulse at expiry

  modport ctrl  (output start, output count, input busy, input done);
  modport timer (input start, input count, output busy, output done);
endinterface : warmup_if

// ### core/warmup_timer.sv
`timescale 1ns/10ps
module warmup_timer (
  input  wire logic  i_mclk,     // System clock
  input  wire logic  i_sys_rst,  // Synchronous reset, active high
  warmup_if.timer    wu          // Start and completion handshake
);

  typedef struct packed {
    logic [lpm_pkg::WU_W-1:0] cnt;   // Cycles left
    logic                     busy;  // Counting
    logic                     done;  // Expiry pulse
  } wu_state_t;

  wu_state_t st;       // Registered state
  wu_state_t next_st;  // Next state

  // Count down from the loaded value; zero expires at once
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (wu.start) begin
      next_st.cnt  = wu.count;
      next_st.busy = (wu.count != lpm_pkg::WU_ZERO);
      next_st.done = (wu.count == lpm_pkg::WU_ZERO);
    end else if (st.busy) begin
      next_st.cnt = st.cnt - lpm_pkg::WU_ONE;
      if (st.cnt == lpm_pkg::WU_ONE) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wu.busy = st.busy;
  assign wu.done = st.done;

endmodule : warmup_timer

// ### core/low_power_mode_controller.sv
// Contract
// R1 - Reset always lands in normal mode
// R2 - Select written first, entry on wait instruction
// R3 - Leave low power on reset or interrupt
// R4 - Events never release; no event-wait entry
// R5 - Software never sets core deep sleep bit
// R6 - Halt stops only the processor core
// R7 - Halt-disabled peripherals freeze their state
// R8 - No watchdog clear by core in halt
// R9 - Full stop halts all, internal oscillator too
// R10 - Full stop exit restarts oscillator, back normal
// R11 - Full stop is 001, halt is 011
// R12 - Stop pins follow port registers; oscillator pin high
// R13 - Configured external interrupt pins stay valid inputs
// R14 - Debug data driver enabled only on valid
// R15 - Stopped modules gated automatically on entry
// R16 - Listed modules remain running per mode
// R17 - Halt peripherals individually selectable by software
// R18 - Clock from internal oscillator after reset, stop
// R19 - Software stops gated peripherals before full stop
// R20 - Release sources per mode: halt broad, stop narrow
// R21 - Interrupt exit from stop runs warm-up first
// R22 - Stop exit resets clock bits, keeps warm-up
// R23 - Reset exit from stop skips warm-up
// R24 - Select sampled when wait instruction retires
`timescale 1ns/10ps
module low_power_mode_controller (
  input  wire logic                          i_mclk,          // System clock, 125 MHz
  input  wire logic                          i_sys_rst,       // Synchronous reset, active high
  input  wire logic                          i_stby_wr,       // Standby control register write strobe
  input  wire logic [lpm_pkg::STBY_W-1:0]    i_stby_data,     // Standby select write data
  input  wire logic                          i_wfi_retire,    // Wait for interrupt instruction retired
  input  wire logic                          i_irq_periph,    // Any enabled peripheral interrupt
  input  wire logic                          i_irq_systick,   // System tick interrupt
  input  wire logic                          i_nmi_wdt,       // Watchdog non-maskable interrupt
  input  wire logic                          i_nmi_lvd,       // Voltage detector non-maskable interrupt
  input  wire logic [lpm_pkg::EXT_INT_N-1:0] i_ext_int,       // External interrupt pins, asynchronous
  input  wire logic [lpm_pkg::EXT_INT_N-1:0] i_ext_int_func,  // Pin set to interrupt function
  input  wire logic [lpm_pkg::EXT_INT_N-1:0] i_ext_int_ie,    // Pin interrupt input enable
  input  wire logic [lpm_pkg::EXT_INT_N-1:0] i_ext_int_wake,  // Clock unit release enable per pin
  input  wire logic [lpm_pkg::MOD_W-1:0]     i_halt_enable,   // Per module run enable in halt
  input  wire logic                          i_clk_cfg_wr,    // Clock configuration write strobe
  input  wire logic [lpm_pkg::CFG_W-1:0]     i_clk_cfg,       // Clock configuration write data
  input  wire logic [lpm_pkg::WU_W-1:0]      i_warmup_count,  // Warm-up count value, kept by software
  input  wire logic                          i_wdt_clear_req, // Core request to clear watchdog
  input  wire logic [lpm_pkg::PORT_W-1:0]    i_port_ie,       // Port input enable bits
  input  wire logic [lpm_pkg::PORT_W-1:0]    i_port_cr,       // Port output control bits
  input  wire logic [lpm_pkg::PORT_W-1:0]    i_port_func_oe,  // Functional output enables in run
  input  wire logic                          i_dbg_sel,       // Pin set as debug data line
  input  wire logic                          i_dbg_valid,     // Debug data currently valid
  input  wire logic                          i_dbg_func_oe,   // Debug output enable in run
  output logic [1:0]                         o_mode,          // Current mode code
  output logic [lpm_pkg::STBY_W-1:0]         o_stby,          // Standby select readback
  output logic [lpm_pkg::CFG_W-1:0]          o_clk_cfg,       // Clock configuration bits
  output logic [lpm_pkg::MOD_W-1:0]          o_module_run,    // Per module clock enables
  output logic                               o_wdt_clear,     // Watchdog clear to the counter
  output logic [lpm_pkg::PORT_W-1:0]         o_port_in_en,    // Port input buffer enables
  output logic [lpm_pkg::PORT_W-1:0]         o_port_out_en,   // Port output driver enables
  output logic [lpm_pkg::EXT_INT_N-1:0]      o_ext_int_in_en, // External interrupt input enables
  output logic                               o_dbg_oe,        // Debug data driver enable
  output logic                               o_osc_out_high,  // Force oscillator output pin high
  output logic                               o_osc_in_en,     // Oscillator input pin honoured
  output logic                               o_warmup_busy    // Warm-up in progress
);

  // Whole controller state in one record
  typedef struct packed {
    lpm_pkg::mode_t                mode;      // Operating mode
    logic [lpm_pkg::STBY_W-1:0]    stby;      // Standby select field
    logic [lpm_pkg::CFG_W-1:0]     cfg;       // Clock configuration
    logic [lpm_pkg::EXT_INT_N-1:0] ext_s1;    // Pin synchroniser, first stage
    logic [lpm_pkg::EXT_INT_N-1:0] ext_s2;    // Pin synchroniser, second stage
    logic [lpm_pkg::MOD_W-1:0]     run;       // Module clock enables
    logic                          wdt_clr;   // Watchdog clear
    logic [lpm_pkg::PORT_W-1:0]    in_en;     // Port input enables
    logic [lpm_pkg::PORT_W-1:0]    out_en;    // Port output enables
    logic [lpm_pkg::EXT_INT_N-1:0] xin_en;    // External interrupt input enables
    logic                          dbg_oe;    // Debug driver enable
    logic                          osc_high;  // Oscillator output forced high
    logic                          osc_in;    // Oscillator input honoured
    logic                          wu_start;  // Warm-up launch pulse
    logic                          wu_busy;   // Warm-up busy copy
    logic [lpm_pkg::WU_W:0]        wu_age;    // Warm-up cycles, for checks
  } ctl_state_t;

  ctl_state_t st;       // Registered state
  ctl_state_t next_st;  // Next state

  warmup_if wu ();      // Link to the warm-up counter

  // Clock enables per mode; halt honours software selection per module
  function automatic logic [lpm_pkg::MOD_W-1:0] run_mask(
    input lpm_pkg::mode_t             m,
    input logic [lpm_pkg::MOD_W-1:0]  halt_en,
    input logic [lpm_pkg::CFG_W-1:0]  cfg
  );
    logic [lpm_pkg::MOD_W-1:0] r;
    r = lpm_pkg::RUN_NONE;
    case (m)
      lpm_pkg::MODE_NORMAL: begin
        // Everything clocked
        r = lpm_pkg::RUN_ALL;
      end
      lpm_pkg::MODE_IDLE: begin
        // Core off, fixed set on, rest per selection
        r = lpm_pkg::HALT_FIXED_RUN | (lpm_pkg::HALT_SELECT & halt_en);  // see R6 see R7 see R17
      end
      lpm_pkg::MODE_STOP: begin
        // Port, clock unit and RAM only
        r = lpm_pkg::STOP_RUN;  // see R9 see R15
      end
      default: begin
        // Stop set plus the oscillator
        r = lpm_pkg::STOP_RUN;  // Held off until the oscillator settles
        r[lpm_pkg::MOD_INTOSC] = 1'b1;  // see R10 see R21
      end
    endcase
    // External oscillator and multiplier only run when software enabled them
    r[lpm_pkg::MOD_EXTOSC] = r[lpm_pkg::MOD_EXTOSC] & cfg[lpm_pkg::CFG_EXT_EN];  // see R17
    r[lpm_pkg::MOD_PLL]    = r[lpm_pkg::MOD_PLL] & cfg[lpm_pkg::CFG_PLL_ON];
    return r;
  endfunction : run_mask

  logic [lpm_pkg::EXT_INT_N-1:0] ext_armed;  // Pins usable as release source
  logic                          stop_wake;  // Release from full stop
  logic                          idle_wake;  // Release from halt

  // Only configured external pins may release full stop
  assign ext_armed = st.ext_s2 & i_ext_int_func & i_ext_int_ie & i_ext_int_wake;
  assign stop_wake = |ext_armed;  // see R20 see R3
  // Events have no wake path here at all, by construction
  assign idle_wake = i_irq_periph | i_irq_systick | i_nmi_wdt | i_nmi_lvd | stop_wake;  // see R20 see R4

  // Next state, mode sequencing and pin control
  always_comb begin
    next_st          = st;
    // Two-flop pin synchroniser
    next_st.ext_s1   = i_ext_int;
    next_st.ext_s2   = st.ext_s1;
    next_st.wu_start = 1'b0;
    next_st.wu_busy  = wu.busy;

    // Age saturates, so a stuck count still trips
    if (st.mode == lpm_pkg::MODE_WARMUP) begin
      if (st.wu_age != '1) begin
        next_st.wu_age = st.wu_age + 1'b1;
      end
    end else begin
      next_st.wu_age = '0;
    end

    // Register writes; software only changes the clock bits in normal mode
    if (i_stby_wr) begin
      next_st.stby = i_stby_data;  // see R2
    end
    if (i_clk_cfg_wr && (st.mode == lpm_pkg::MODE_NORMAL)) begin
      next_st.cfg = i_clk_cfg;
    end

    case (st.mode)
      lpm_pkg::MODE_NORMAL: begin
        // Registered select value is used, so a same cycle write is too late
        if (i_wfi_retire) begin  // see R24 see R2
          if (st.stby == lpm_pkg::STBY_HALT) begin  // see R11
            next_st.mode = lpm_pkg::MODE_IDLE;
          end else if (st.stby == lpm_pkg::STBY_FULL_STOP) begin  // see R11
            next_st.mode = lpm_pkg::MODE_STOP;
          end
        end
      end
      lpm_pkg::MODE_IDLE: begin
        // Any listed source ends halt
        if (idle_wake) begin
          next_st.mode = lpm_pkg::MODE_NORMAL;  // see R3
        end
      end
      lpm_pkg::MODE_STOP: begin
        // Armed pins only; clock bits reset
        if (stop_wake) begin
          next_st.mode     = lpm_pkg::MODE_WARMUP;  // see R21
          next_st.wu_start = 1'b1;
          next_st.cfg      = lpm_pkg::CFG_RESET;  // see R22 see R18
        end
      end
      default: begin
        // Hold until counter expiry
        if (wu.done) begin
          next_st.mode = lpm_pkg::MODE_NORMAL;  // see R10 see R21
        end
      end
    endcase

    next_st.run = run_mask(next_st.mode, i_halt_enable, next_st.cfg);  // see R15 see R16

    // Core cannot clear the watchdog outside normal mode
    next_st.wdt_clr = i_wdt_clear_req && (next_st.mode == lpm_pkg::MODE_NORMAL);  // see R8

    // Pins: full stop hands control to the port registers
    next_st.xin_en = i_ext_int_func & i_ext_int_ie;  // see R13
    if (next_st.mode == lpm_pkg::MODE_STOP) begin
      // Port registers decide the pins
      next_st.in_en    = i_port_ie;  // see R12
      next_st.out_en   = i_port_cr;  // see R12
      next_st.dbg_oe   = i_dbg_sel & i_dbg_valid;  // see R14
      next_st.osc_high = 1'b1;  // see R12
      next_st.osc_in   = 1'b0;  // see R12
    end else begin
      // Functional enables rule
      next_st.in_en    = i_port_ie;
      next_st.out_en   = i_port_func_oe;
      next_st.dbg_oe   = i_dbg_sel & i_dbg_func_oe;
      next_st.osc_high = 1'b0;
      next_st.osc_in   = 1'b1;
    end
  end

  // State register; reset goes straight to normal, no warm-up
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      // Constants only; zero covers the rest
      st          <= '0;
      st.mode     <= lpm_pkg::MODE_NORMAL;  // see R1 see R23
      st.stby     <= lpm_pkg::STBY_RESET;
      st.cfg      <= lpm_pkg::CFG_RESET;  // see R18
      st.run      <= lpm_pkg::RUN_ALL;
      st.in_en    <= '0;
      st.osc_in   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Warm-up counter hookup
  assign wu.start = st.wu_start;
  // Software owns the count; kept over stop
  assign wu.count = i_warmup_count;  // see R22

  // Same clock and reset as the controller
  warmup_timer u_warmup (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .wu        (wu)
  );

  // Outputs straight from the state record
  assign o_mode          = st.mode;
  assign o_stby          = st.stby;
  assign o_clk_cfg       = st.cfg;

  // Gating and watchdog
  assign o_module_run    = st.run;
  assign o_wdt_clear     = st.wdt_clr;

  // Pin control
  assign o_port_in_en    = st.in_en;
  assign o_port_out_en   = st.out_en;
  assign o_ext_int_in_en = st.xin_en;
  assign o_dbg_oe        = st.dbg_oe;
  assign o_osc_out_high  = st.osc_high;
  assign o_osc_in_en     = st.osc_in;

  // Warm-up status
  assign o_warmup_busy   = st.wu_busy;

  // Checks on the sequencing, all on the system clock
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  // Wait retiring with full stop selected
  sequence s_enter_stop;
    (st.mode == lpm_pkg::MODE_NORMAL) && i_wfi_retire && (st.stby == lpm_pkg::STBY_FULL_STOP);
  endsequence

  // Pin release, warm-up one edge later
  sequence s_stop_exit;
    (st.mode == lpm_pkg::MODE_STOP) && stop_wake ##1 (st.mode == lpm_pkg::MODE_WARMUP);
  endsequence

  // Reset wins in every mode
  a_reset_to_normal: assert property (disable iff (1'b0) i_sys_rst |=> (st.mode == lpm_pkg::MODE_NORMAL)  // see R1
    && (st.cfg == lpm_pkg::CFG_RESET)) else $error("reset did not return to normal");

  // Halt entry on the wait
  a_halt_entry: assert property ((st.mode == lpm_pkg::MODE_NORMAL) && i_wfi_retire  // see R2
    && (st.stby == lpm_pkg::STBY_HALT) |=> (st.mode == lpm_pkg::MODE_IDLE))
    else $error("halt not entered");

  // No entry without the wait
  a_no_entry_wo_wfi: assert property ((st.mode == lpm_pkg::MODE_NORMAL) && !i_wfi_retire  // see R24
    |=> (st.mode == lpm_pkg::MODE_NORMAL)) else $error("low power entered without wait");

  // Full stop gating and oscillator pins
  a_stop_entry_gate: assert property (s_enter_stop |=> (st.mode == lpm_pkg::MODE_STOP)  // see R9
    && (st.run == lpm_pkg::STOP_RUN) && st.osc_high && !st.osc_in)
    else $error("full stop entry wrong");

  // Halt ends on any listed source
  a_idle_release: assert property ((st.mode == lpm_pkg::MODE_IDLE) && idle_wake  // see R3
    |=> (st.mode == lpm_pkg::MODE_NORMAL) && st.run[lpm_pkg::MOD_CORE])
    else $error("halt not released");

  // Full stop ignores all but armed pins
  a_stop_holds: assert property ((st.mode == lpm_pkg::MODE_STOP) && !stop_wake  // see R20
    |=> (st.mode == lpm_pkg::MODE_STOP)) else $error("full stop left without pin");

  // Stop exit clears clock bits, starts count
  a_stop_exit_cfg: assert property (s_stop_exit |-> (st.cfg == lpm_pkg::CFG_RESET) && st.wu_start)  // see R22
    else $error("stop exit sequence wrong");

  // Warm-up age never past its count plus one
  a_warmup_bounded: assert property ((st.mode == lpm_pkg::MODE_WARMUP)  // see R21
    |-> (st.wu_age <= ({1'b0, i_warmup_count} + 1'b1)))
    else $error("warm-up outlasted its count");

  // Oscillator runs, core gated in warm-up
  a_warmup_clocks: assert property ((st.mode == lpm_pkg::MODE_WARMUP)  // see R10
    |-> st.run[lpm_pkg::MOD_INTOSC] && !st.run[lpm_pkg::MOD_CORE])
    else $error("warm-up gating wrong");

  // Halt gates the core, keeps the fixed set running
  a_halt_core_off: assert property ((st.mode == lpm_pkg::MODE_IDLE) |-> !st.run[lpm_pkg::MOD_CORE]  // see R6
    && ((st.run & lpm_pkg::HALT_FIXED_RUN) == lpm_pkg::HALT_FIXED_RUN))
    else $error("halt gating wrong");

  // Clock bits kept across halt
  a_halt_cfg_kept: assert property ((st.mode == lpm_pkg::MODE_IDLE) |=> $stable(st.cfg))  // see R22
    else $error("clock bits changed in halt");

  // No watchdog clear in low power
  a_wdt_blocked: assert property ((st.mode != lpm_pkg::MODE_NORMAL) |-> !st.wdt_clr)  // see R8
    else $error("watchdog cleared in low power");

  // Debug driver off without data
  a_dbg_stop_oe: assert property ((next_st.mode == lpm_pkg::MODE_STOP) && !i_dbg_valid  // see R14
    |=> !st.dbg_oe) else $error("debug driver on without data");

  // Expiry returns to normal
  a_warmup_done: assert property ((st.mode == lpm_pkg::MODE_WARMUP) && wu.done  // see R10
    |=> (st.mode == lpm_pkg::MODE_NORMAL) && st.run[lpm_pkg::MOD_CORE])
    else $error("warm-up end not honoured");

endmodule : low_power_mode_controller

// ### tb/lpm_partner.sv
`timescale 1ns/10ps
// Core and interrupt sources on the far side of the controller
module lpm_partner (
  input  wire logic       i_mclk,    // System clock
  input  wire logic       i_sys_rst, // Synchronous reset, active high
  input  wire logic [1:0] i_mode,    // Controller mode code
  input  wire logic [9:0] i_raise,   // Raise pulses: periph, tick, wdt, lvd, six pins
  output logic      [3:0] o_irq,     // Peripheral, tick and two nmi requests
  output logic      [5:0] o_pins     // External interrupt pin levels
);
  logic [9:0] req;  // Held request levels

  // Levels held until the core is back in normal mode, so the handler can start
  // No event line exists, only interrupts can release
  // The core model never sets its deep sleep bit
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      req <= 10'h000;
    end else begin
      req <= (req & {10{i_mode != 2'h0}}) | i_raise;
    end
  end

  assign o_irq  = req[3:0];
  assign o_pins = req[9:4];
endmodule : lpm_partner

// ### tb/test_low_power_mode_controller.sv
`timescale 1ns/10ps
// Self-checking bench: driver notes expectations, monitor compares them
module test_low_power_mode_controller;
  typedef struct packed {
    logic [3:0]  sel;  // Which output
    logic [14:0] val;  // Expected value
  } note_t;

  logic        i_mclk, i_sys_rst, stby_wr, wait_for_interrupt_instruction, cfg_wr, wdt_req, dbg_sel, dbg_valid, dbg_foe;
  logic [2:0]  stby_d, stby;
  logic [5:0]  efunc, eie, ewake, cfg, ccfg, pins, eien;
  logic [14:0] halt_en, run;
  logic [11:0] wu;
  logic [7:0]  p_ie, p_cr, p_oe, poe, pien;
  logic [9:0]  raise;
  logic [3:0]  irq;
  logic [1:0]  mode;
  logic        wclr, dbg_oe, osc_hi, osc_in, wbusy;
  note_t       q[$];     // Pending expectations
  event        ev;       // Expectations ready to compare
  int          n_errors, cmp_count;
  logic [15:0] rnd;      // Random source state
  string       nm[11] = '{"mode", "stby", "clk_cfg", "module_run", "wdt_clear", "port_out_en", "dbg_oe",
                          "osc_pins", "ext_int_in_en", "warmup_busy", "port_in_en"};

  low_power_mode_controller u_dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_stby_wr(stby_wr), .i_stby_data(stby_d), .i_wfi_retire(wait_for_interrupt_instruction),
    .i_irq_periph(irq[0]), .i_irq_systick(irq[1]), .i_nmi_wdt(irq[2]), .i_nmi_lvd(irq[3]), .i_ext_int(pins),
    .i_ext_int_func(efunc), .i_ext_int_ie(eie), .i_ext_int_wake(ewake), .i_halt_enable(halt_en),
    .i_clk_cfg_wr(cfg_wr), .i_clk_cfg(cfg), .i_warmup_count(wu), .i_wdt_clear_req(wdt_req), .i_port_ie(p_ie),
    .i_port_cr(p_cr), .i_port_func_oe(p_oe), .i_dbg_sel(dbg_sel), .i_dbg_valid(dbg_valid),
    .i_dbg_func_oe(dbg_foe), .o_mode(mode), .o_stby(stby), .o_clk_cfg(ccfg), .o_module_run(run),
    .o_wdt_clear(wclr), .o_port_in_en(pien), .o_port_out_en(poe), .o_ext_int_in_en(eien), .o_dbg_oe(dbg_oe),
    .o_osc_out_high(osc_hi), .o_osc_in_en(osc_in), .o_warmup_busy(wbusy));

  lpm_partner u_partner (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_mode(mode), .i_raise(raise),
    .o_irq(irq), .o_pins(pins));

  // Free-running system clock, 8 ns period
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // Sixteen bit shift register for stimulus values
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // Output picked by a note selector
  function automatic logic [14:0] seen(input logic [3:0] s);
    case (s)
      4'h0: seen = {13'h0000, mode};
      4'h1: seen = {12'h000, stby};
      4'h2: seen = {9'h000, ccfg};
      4'h3: seen = run;
      4'h4: seen = {14'h0000, wclr};
      4'h5: seen = {7'h00, poe};
      4'h6: seen = {14'h0000, dbg_oe};
      4'h7: seen = {13'h0000, osc_hi, osc_in};
      4'h8: seen = {9'h000, eien};
      4'hA: seen = {7'h00, pien};
      default: seen = {14'h0000, wbusy};
    endcase
  endfunction : seen

  task automatic check(input string name, input logic [14:0] exp, input logic [14:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic put(input logic [3:0] s, input logic [14:0] v);
    q.push_back('{s, v});
    -> ev;
  endtask : put

  // Write the select, then retire the wait instruction with a late write beside it
  task automatic enter(input logic [2:0] sel, input logic [2:0] late);
    stby_wr = 1'b1;
    stby_d = sel;
    @(negedge i_mclk);
    stby_d = late;
    wait_for_interrupt_instruction = 1'b1;
    @(negedge i_mclk);
    stby_wr = 1'b0;
    wait_for_interrupt_instruction = 1'b0;
  endtask : enter

  // Bounded wait for a mode, then note it
  task automatic wait_mode(input logic [1:0] m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(negedge i_mclk);
    put(4'h0, {13'h0000, m});
  endtask : wait_mode

  task automatic pulse(input logic [9:0] r);
    raise = r;
    @(negedge i_mclk);
    raise = 10'h000;
  endtask : pulse

  task automatic test_done;
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // Monitor: takes the oldest notes whenever results are posted
  initial begin
    note_t n;
    forever begin
      @(ev);
      while (q.size() > 0) begin
        n = q.pop_front();
        check(nm[n.sel], n.val, seen(n.sel));
      end
    end
  end

  // Watchdog, far beyond the hundred or so cycles the run needs
  initial begin
    #20000;
    n_errors++;
    test_done;
  end

  // Driver
  initial begin
    {stby_wr, wait_for_interrupt_instruction, cfg_wr, wdt_req, dbg_valid, stby_d, halt_en, cfg, raise, p_ie, p_cr, p_oe} = '0;
    {efunc, eie, ewake} = {6'h3F, 6'h3F, 6'h01};
    {dbg_sel, dbg_foe, wu, rnd} = {1'b1, 1'b1, 12'h014, 16'hBF6F};
    i_sys_rst = 1'b1;
    repeat (12) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    put(4'h0, 15'h0000);
    put(4'h2, 15'h0004);
    put(4'h3, 15'h7FFF);
    rnd = lfsr(rnd);
    {p_oe, p_cr, p_ie} = {rnd[7:0], rnd[15:8], rnd[11:4]};
    wdt_req = 1'b1;
    @(negedge i_mclk);
    @(negedge i_mclk);
    put(4'h5, {7'h00, p_oe});
    put(4'h4, 15'h0001);
    // Halt, released by each of the four interrupt requests in turn; late select write must not matter
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      halt_en = rnd[14:0];
      enter(3'h3, 3'h1);
      wait_mode(2'h1, 4);
      put(4'h1, 15'h0001);
      put(4'h3, 15'h7216 | (halt_en & 15'h0DE8 & ~15'h0C00));
      put(4'h4, 15'h0000);
      cfg_wr = 1'b1;
      cfg = 6'h3F;
      @(negedge i_mclk);
      cfg_wr = 1'b0;
      pulse(10'h001 << k);
      wait_mode(2'h0, 4);
      put(4'h2, 15'h0004);
    end
    // Reserved select codes leave the mode alone
    for (int v = 0; v < 8; v++) begin
      if (v != 1 && v != 3) begin
        enter(v[2:0], v[2:0]);
        repeat (3) @(negedge i_mclk);
        put(4'h0, 15'h0000);
      end
    end
    // Full stop with a changed clock setup, released by an armed pin; pending interrupts and an unarmed pin are ignored
    cfg_wr = 1'b1;
    @(negedge i_mclk);
    cfg_wr = 1'b0;
    rnd = lfsr(rnd);
    {p_cr, dbg_valid, efunc} = {rnd[7:0], rnd[8], rnd[14:9] | 6'h01};
    @(negedge i_mclk);
    put(4'h2, 15'h003F);
    enter(3'h1, 3'h1);
    wait_mode(2'h2, 4);
    put(4'h3, 15'h4204);
    put(4'h7, 15'h0002);
    put(4'h5, {7'h00, p_cr});
    put(4'h6, {14'h0000, dbg_sel & dbg_valid});
    put(4'h8, {9'h000, efunc & eie});
    put(4'hA, {7'h00, p_ie});
    put(4'h4, 15'h0000);
    pulse(10'h02F);
    repeat (8) @(negedge i_mclk);
    put(4'h0, 15'h0002);
    pulse(10'h010);
    wait_mode(2'h3, 6);
    put(4'h2, 15'h0004);
    put(4'h3, 15'h6204);
    repeat (15) @(negedge i_mclk);
    put(4'h0, 15'h0003);
    put(4'h9, 15'h0001);
    wait_mode(2'h0, 30);
    // Full stop ended by reset: straight to normal, no warm-up
    enter(3'h1, 3'h1);
    wait_mode(2'h2, 4);
    i_sys_rst = 1'b1;
    @(negedge i_mclk);
    i_sys_rst = 1'b0;
    put(4'h0, 15'h0000);
    put(4'h9, 15'h0000);
    put(4'h2, 15'h0004);
    @(negedge i_mclk);
    #1;
    test_done;
  end
endmodule : test_low_power_mode_controller
